// >>> hdl/rtr_pkg.sv
// package for the tuning register host controller
// assumes a 25 MHz system clock; device registers are 8 bits with 7-bit addresses
package rtr_pkg;
	localparam int CLK_HZ = 25000000;
	// device tuning register addresses and values
	localparam logic [6:0] DEV_SENS_ADDR = 7'h58;
	localparam logic [6:0] DEV_PA1_ADDR = 7'h5A;
	localparam logic [6:0] DEV_PA2_ADDR = 7'h5C;
	localparam logic [6:0] DEV_FADE_ADDR = 7'h6F;
	localparam logic [6:0] DEV_OFFS_ADDR = 7'h71;
	localparam logic [7:0] SENS_NORMAL = 8'h1B;
	localparam logic [7:0] SENS_HIGH = 8'h2D;
	localparam logic [7:0] PA1_NORMAL = 8'h55;
	localparam logic [7:0] PA1_HIGH = 8'h5D;
	localparam logic [7:0] PA2_NORMAL = 8'h70;
	localparam logic [7:0] PA2_HIGH = 8'h7C;
	localparam logic [7:0] FADE_RESET = 8'h30;
	localparam logic [7:0] FADE_OFF = 8'h00;
	localparam logic [7:0] FADE_NARROW_ON = 8'h20;
	localparam logic [7:0] FADE_NARROW_OFF = 8'h30;
	localparam logic [7:0] OFFS_RESET = 8'h00;
	localparam int OFFS_STEP_HZ = 488;
	// timing, in printed units and in cycles
	localparam int POR_WAIT_MS = 10;
	localparam int POR_WAIT_CYC = POR_WAIT_MS * (CLK_HZ / 1000);
	localparam int RST_PULSE_US = 100;
	localparam int RST_PULSE_CYC = (RST_PULSE_US * (CLK_HZ / 1000000));
	localparam int RST_WAIT_MS = 5;
	localparam int RST_WAIT_CYC = RST_WAIT_MS * (CLK_HZ / 1000);
	localparam int SPI_HALF_CYC = 4;
	// own APB register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_XFER = 8'h04;
	localparam logic [7:0] REG_STAT = 8'h08;
	// field positions
	localparam int CTRL_CMD_LSB = 0;
	localparam int CTRL_NARROW_BIT = 8;
	localparam int CTRL_SENS_BIT = 9;
	localparam int XFER_DATA_LSB = 8;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_READY_BIT = 1;
	localparam int STAT_ACT_BIT = 2;
	localparam int STAT_REFUSE_BIT = 3;
	localparam int STAT_RDATA_LSB = 8;
	// commands written to the control register
	typedef enum logic [2:0] {
		CMD_NONE, CMD_WRITE, CMD_READ, CMD_TX_HIGH, CMD_RX_RESTORE, CMD_FADE, CMD_RESET,
		CMD_SENS
	} rtr_cmd_e;
	typedef enum {ST_POR_WAIT, ST_IDLE, ST_RST_DRIVE, ST_RST_WAIT, ST_FRAME, ST_GAP} rtr_state_e;
endpackage

// >>> hdl/rtr_host.sv
// host controller: APB register slave that sequences tuning-register accesses to the radio
// over a 4-wire serial port and manages its power-on and manual reset timing.
// assumes the radio samples data on the rising serial clock and reset pin floats when released.
// Functional notes
// - first amp tuning register resets to 0x55 and is written 0x5D for high-power transmit.
// - before receive or low-power path use, the first amp tuning register goes back to 0x55.
// - second amp tuning register resets to 0x70 and is written 0x7C for high-power transmit.
// - before receive or low-power path use, the second amp tuning register goes back to 0x70.
// - with narrow index correction on, the fading gain register is set to 0x20.
// - with narrow index correction off, the fading gain register is set to 0x30.
// - no serial access until 10 ms after the end of power-on reset; the code ends this wait early once the clock output moves.
// - the reset pin is left undriven during power-on reset.
// - activity on the radio clock output means the radio is ready.
// - a manual reset drives the reset pin high for 100 us and then releases it.
// - after releasing the reset pin, wait 5 ms before any access; the code ends this wait early once the clock output moves.
`timescale 1ns/1ns
module rtr_host #(
	parameter int POR_CYC = rtr_pkg::POR_WAIT_CYC,
	parameter int RSTW_CYC = rtr_pkg::RST_WAIT_CYC,
	parameter int HALF_CYC = rtr_pkg::SPI_HALF_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial port to the radio
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_mosi,
	input wire logic spi_miso,
	// radio reset pin, three-state
	output logic reset_pin_o,
	output logic reset_pin_oe,
	input wire logic reset_pin_i,
	// radio clock output, used as a readiness sign
	input wire logic clock_output_pin
);
	import rtr_pkg::*;

	localparam int CW = 20;
	localparam logic [CW-1:0] POR_LAST = CW'(POR_CYC - 1);
	localparam logic [CW-1:0] RSTW_LAST = CW'(RSTW_CYC - 1);
	localparam logic [CW-1:0] PULSE_LAST = CW'(RST_PULSE_CYC - 1);
	localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

	rtr_state_e state_r;
	logic [CW-1:0] wait_r;
	logic [7:0] half_r;
	logic [4:0] edge_r;
	logic [15:0] tx_r;
	logic [7:0] rx_r;
	logic [6:0] addr_r;
	logic [7:0] wdata_r;
	logic narrow_r;
	logic sens_r;
	logic ready_r;
	logic act_r;
	logic refuse_r;
	logic [7:0] rdata_r;
	logic [6:0] fr_addr_r [2];
	logic [7:0] fr_data_r [2];
	logic fr_rd_r;
	logic fr_two_r;
	logic fr_idx_r;
	logic [2:0] miso_s;
	logic [2:0] clko_s;
	logic unused_in;

	logic apb_wr;
	logic cmd_go;
	rtr_cmd_e cmd;
	logic clko_edge;
	logic half_tick;

	// inputs that no logic needs, gathered so they are visibly consumed
	assign unused_in = reset_pin_i | (|pwdata[31:16]) | pwdata[7];
	// apb decode; writes land on the access edge because pready never stalls
	// a command launches only from a control write with a non-zero code
	assign apb_wr = psel & penable & pwrite;
	assign cmd = rtr_cmd_e'(pwdata[CTRL_CMD_LSB +: 3]);
	assign cmd_go = apb_wr && (paddr == REG_CTRL) && (cmd != CMD_NONE);
	assign half_tick = (half_r == HALF_LAST);

	// three-stage synchronisers; edge detection reads only the second and third stages
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			miso_s <= 3'h0;
			clko_s <= 3'h0;
		end else begin
			miso_s <= {miso_s[1:0], spi_miso};
			clko_s <= {clko_s[1:0], clock_output_pin};
		end
	end
	assign clko_edge = clko_s[2] ^ clko_s[1];

	// readiness sign from clock output toggling, cleared when a reset starts
	// an edge in the same cycle wins; a stale edge while driving is cleared again next cycle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			act_r <= 1'b0;
		end else if (clko_edge) begin
			act_r <= 1'b1;
		end else if (state_r == ST_RST_DRIVE) begin
			act_r <= 1'b0;
		end
	end

	// software settings and transfer fields
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			narrow_r <= 1'b0;
			sens_r <= 1'b0;
			addr_r <= 7'h00;
			wdata_r <= 8'h00;
		end else if (apb_wr && paddr == REG_CTRL) begin
			narrow_r <= pwdata[CTRL_NARROW_BIT];
			sens_r <= pwdata[CTRL_SENS_BIT];
		end else if (apb_wr && paddr == REG_XFER) begin
			addr_r <= pwdata[6:0];
			wdata_r <= pwdata[XFER_DATA_LSB +: 8];
		end
	end

	// refused command flag: set when a command arrives while busy or not ready
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			refuse_r <= 1'b0;
		end else if (cmd_go) begin
			refuse_r <= (state_r != ST_IDLE);
		end
	end

	// frame list built from the command; presets carry the documented values
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fr_addr_r[0] <= 7'h00;
			fr_addr_r[1] <= 7'h00;
			fr_data_r[0] <= 8'h00;
			fr_data_r[1] <= 8'h00;
			fr_rd_r <= 1'b0;
			fr_two_r <= 1'b0;
		end else if (cmd_go && state_r == ST_IDLE) begin
			fr_rd_r <= (cmd == CMD_READ);
			fr_two_r <= (cmd == CMD_TX_HIGH) || (cmd == CMD_RX_RESTORE);
			fr_addr_r[1] <= DEV_PA2_ADDR;
			fr_data_r[1] <= (cmd == CMD_TX_HIGH) ? PA2_HIGH : PA2_NORMAL;
			case (cmd)
				CMD_TX_HIGH: begin
					fr_addr_r[0] <= DEV_PA1_ADDR;
					fr_data_r[0] <= PA1_HIGH;
				end
				CMD_RX_RESTORE: begin
					fr_addr_r[0] <= DEV_PA1_ADDR;
					fr_data_r[0] <= PA1_NORMAL;
				end
				CMD_FADE: begin
					fr_addr_r[0] <= DEV_FADE_ADDR;
					fr_data_r[0] <= pwdata[CTRL_NARROW_BIT] ? FADE_NARROW_ON : FADE_NARROW_OFF;
				end
				CMD_SENS: begin
					fr_addr_r[0] <= DEV_SENS_ADDR;
					fr_data_r[0] <= pwdata[CTRL_SENS_BIT] ? SENS_HIGH : SENS_NORMAL;
				end
				default: begin
					fr_addr_r[0] <= addr_r;
					fr_data_r[0] <= wdata_r;
				end
			endcase
		end
	end

	// main sequencer: reset timing, then serial frames
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			state_r <= ST_POR_WAIT;
			wait_r <= '0;
			ready_r <= 1'b0;
			fr_idx_r <= 1'b0;
		end else begin
			case (state_r)
				ST_POR_WAIT: begin
					// pin stays floating; wait out the power-on delay or see the clock run
					if (wait_r == POR_LAST || act_r) begin
						state_r <= ST_IDLE;
						ready_r <= 1'b1;
						wait_r <= '0;
					end else begin
						wait_r <= wait_r + 1'b1;
					end
				end
				ST_IDLE: begin
					fr_idx_r <= 1'b0;
					if (cmd_go && cmd == CMD_RESET) begin
						state_r <= ST_RST_DRIVE;
						ready_r <= 1'b0;
						wait_r <= '0;
					end else if (cmd_go) begin
						state_r <= ST_FRAME;
					end
				end
				ST_RST_DRIVE: begin
					if (wait_r == PULSE_LAST) begin
						state_r <= ST_RST_WAIT;
						wait_r <= '0;
					end else begin
						wait_r <= wait_r + 1'b1;
					end
				end
				ST_RST_WAIT: begin
					// the clock output stops under reset, so a fresh edge marks the restart
					if (wait_r == RSTW_LAST || act_r) begin
						state_r <= ST_IDLE;
						ready_r <= 1'b1;
						wait_r <= '0;
					end else begin
						wait_r <= wait_r + 1'b1;
					end
				end
				ST_FRAME: begin
					if (half_tick && edge_r == 5'd31) begin
						state_r <= ST_GAP;
					end
				end
				ST_GAP: begin
					// one half period with select high between frames
					if (half_tick) begin
						if (fr_two_r && !fr_idx_r) begin
							fr_idx_r <= 1'b1;
							state_r <= ST_FRAME;
						end else begin
							state_r <= ST_IDLE;
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// half-period divider for the serial clock; restarts at every frame and gap
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			half_r <= 8'h00;
		end else if (state_r != ST_FRAME && state_r != ST_GAP) begin
			half_r <= 8'h00;
		end else if (half_tick) begin
			half_r <= 8'h00;
		end else begin
			half_r <= half_r + 8'h01;
		end
	end

	// serial shifter: mode 0, msb first, write flag then address then data
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			edge_r <= 5'd0;
			tx_r <= 16'h0000;
			rx_r <= 8'h00;
			spi_sck <= 1'b0;
			spi_cs_n <= 1'b1;
			spi_mosi <= 1'b0;
		end else if (state_r == ST_FRAME) begin
			spi_cs_n <= 1'b0;
			// the frame list and its index settle on the edge that enters this state,
			// so the shift word is loaded in the first frame cycle, not before it;
			// loading any earlier would send the previous frame's contents again
			if (edge_r == 5'd0 && half_r == 8'h00) begin
				tx_r <= {~fr_rd_r, fr_addr_r[fr_idx_r], fr_data_r[fr_idx_r]};
				spi_mosi <= ~fr_rd_r;
			end else begin
				spi_mosi <= tx_r[15];
			end
			if (half_tick) begin
				edge_r <= edge_r + 5'd1;
				spi_sck <= ~edge_r[0] & (edge_r != 5'd31);
				if (!edge_r[0]) begin
					rx_r <= {rx_r[6:0], miso_s[2]};
				end else begin
					tx_r <= {tx_r[14:0], 1'b0};
				end
			end
		end else begin
			edge_r <= 5'd0;
			spi_sck <= 1'b0;
			spi_cs_n <= 1'b1;
			spi_mosi <= 1'b0;
			tx_r <= {~fr_rd_r, fr_addr_r[fr_idx_r], fr_data_r[fr_idx_r]};
		end
	end

	// read data captured at the end of a read frame
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rdata_r <= 8'h00;
		end else if (state_r == ST_GAP && fr_rd_r && half_r == 8'h00) begin
			rdata_r <= rx_r;
		end
	end

	// reset pin: driven high only during the manual pulse, floating otherwise
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			reset_pin_o <= 1'b0;
			reset_pin_oe <= 1'b0;
		end else begin
			reset_pin_o <= (state_r == ST_RST_DRIVE);
			reset_pin_oe <= (state_r == ST_RST_DRIVE);
		end
	end

	// apb read mux; zero wait states, error on unmapped offsets
	always_comb begin
		prdata = 32'h0000_0000;
		pslverr = 1'b0;
		if (paddr == REG_CTRL) begin
			prdata[CTRL_NARROW_BIT] = narrow_r;
			prdata[CTRL_SENS_BIT] = sens_r;
		end else if (paddr == REG_XFER) begin
			prdata[6:0] = addr_r;
			prdata[XFER_DATA_LSB +: 8] = wdata_r;
		end else if (paddr == REG_STAT) begin
			prdata[STAT_BUSY_BIT] = (state_r != ST_IDLE);
			prdata[STAT_READY_BIT] = ready_r;
			prdata[STAT_ACT_BIT] = act_r;
			prdata[STAT_REFUSE_BIT] = refuse_r;
			prdata[STAT_RDATA_LSB +: 8] = rdata_r;
		end else begin
			pslverr = psel & penable;
		end
	end
	assign pready = 1'b1;

endmodule

// >>> bench/rtr_host_assertions.sv
// checker for the tuning register host: reset pin, quiet times, frame shape, apb answers
// assumes a bind onto rtr_host; a moving radio clock output may end a wait early
`timescale 1ns/1ns
module rtr_host_assertions #(
	parameter int POR_CYC = 200,
	parameter int RSTW_CYC = 100,
	parameter int HALF_CYC = 4
) (
	// clock, reset, apb
	input wire logic clock,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// radio pins
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	input wire logic reset_pin_oe,
	input wire logic clock_output_pin
);
	int quiet;
	int oe_cnt;
	int cs_cnt;
	logic seen_r;
	logic pin_r;
	logic man_r;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// quiet time since a reset; void once the radio clock output moves
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			quiet <= 0;
			seen_r <= 1'b0;
			man_r <= 1'b0;
		end else if (reset_pin_oe) begin
			quiet <= 0;
			seen_r <= 1'b0;
			man_r <= 1'b1;
		end else begin
			quiet <= quiet + 1;
			seen_r <= seen_r | (clock_output_pin != pin_r);
		end
	end
	// lengths of the reset pulse and of the select low time
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			pin_r <= 1'b0;
			oe_cnt <= 0;
			cs_cnt <= 0;
		end else begin
			pin_r <= clock_output_pin;
			oe_cnt <= reset_pin_oe ? oe_cnt + 1 : 0;
			cs_cnt <= spi_cs_n ? 0 : cs_cnt + 1;
		end
	end
	por_quiet_a: assert property (!man_r && !seen_r && quiet < POR_CYC |-> spi_cs_n)
		else $error("frame in power-on wait");
	por_float_a: assert property (!man_r && !seen_r && quiet < POR_CYC |-> !reset_pin_oe)
		else $error("reset pin driven in power-on wait");
	rst_pulse_a: assert property ($fell(reset_pin_oe) |-> oe_cnt == 2500)
		else $error("reset pulse length wrong");
	rst_wait_a: assert property (man_r && !seen_r && quiet < RSTW_CYC |-> spi_cs_n)
		else $error("frame too soon after reset");
	frame_len_a: assert property ($rose(spi_cs_n) |-> cs_cnt == 32 * HALF_CYC)
		else $error("select low time wrong");
	sck_half_a: assert property ($changed(spi_sck) |=> $stable(spi_sck) [*3])
		else $error("short serial half period");
	mosi_hold_a: assert property (!spi_cs_n && spi_sck |-> $stable(spi_mosi))
		else $error("data moved while clock high");
	apb_unmap_a: assert property (psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08})
		|-> pslverr && prdata == 32'h0)
		else $error("unmapped access answered");
	apb_ready_a: assert property (psel && penable |-> pready)
		else $error("access phase stalled");
endmodule
bind rtr_host rtr_host_assertions #(
	.POR_CYC(POR_CYC), .RSTW_CYC(RSTW_CYC), .HALF_CYC(HALF_CYC)
) u_rtr_host_assertions (
	.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .spi_sck(spi_sck),
	.spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .reset_pin_oe(reset_pin_oe),
	.clock_output_pin(clock_output_pin)
);

// >>> bench/rtr_dev.sv
// radio model: five tuning registers behind a mode 0 serial port, reset and clock output
// assumes 16-bit frames, first bit high for a write; a released reset pin reads low
`timescale 1ns/1ns
module rtr_dev #(
	parameter int READY_OSC = 19
) (
	// power-on and reset pin
	input wire logic por_n,
	input wire logic reset_pin,
	// serial port
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	// ready sign
	output logic clock_output_pin
);
	logic [7:0] regs [128];
	logic [15:0] sh = 16'h0000;
	logic [6:0] adr = 7'h00;
	logic osc = 1'b0;
	logic bit_r = 1'b0;
	int nbit = 0;
	int up = 0;
	wire logic dev_rst = !por_n || reset_pin;
	// own oscillator; the clock output stays still until the radio is up
	always #160 osc = ~osc;
	always @(posedge osc or posedge dev_rst) begin
		if (dev_rst) up = 0;
		else if (up < READY_OSC) up = up + 1;
	end
	assign clock_output_pin = osc && up >= READY_OSC;
	// either reset restores defaults; a write lands on the 16th rising edge
	always @(posedge spi_sck or posedge dev_rst) begin
		if (dev_rst) begin
			foreach (regs[i]) regs[i] = 8'h00;
			regs[7'h58] = 8'h1B;
			regs[7'h5A] = 8'h55;
			regs[7'h5C] = 8'h70;
			regs[7'h6F] = 8'h30;
			regs[7'h71] = 8'h00;
			nbit = 0;
		end else begin
			sh = {sh[14:0], spi_mosi};
			nbit = nbit + 1;
			if (nbit == 8) adr = sh[6:0];
			if (nbit == 16 && sh[15]) regs[sh[14:8]] = sh[7:0];
			if (nbit == 16) nbit = 0;
		end
	end
	// read data leaves on the falling edge, msb first
	always @(negedge spi_sck) begin
		if (nbit >= 8) bit_r = regs[adr][15 - nbit];
	end
	// a deselected line shows the inverse of its last value
	assign spi_miso = spi_cs_n ? ~bit_r : bit_r;
endmodule

// >>> bench/rtr_host_tb.sv
// bench for the tuning register host with the radio model on the far side
// assumes rtr_dev as the radio and the checker bound to the host
`timescale 1ns/1ns
module rtr_host_tb;
	import rtr_pkg::*;
	logic clock = 1'b0;
	logic rstn = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, sck, cs_n, mosi, miso, rst_o, rst_oe, clk_out;
	wire logic rst_pin = rst_oe ? rst_o : 1'b0; // pulled down when released
	int n_mismatch = 0;
	int checks = 0;
	int ref_r [int];
	int adr [5] = '{DEV_SENS_ADDR, DEV_PA1_ADDR, DEV_PA2_ADDR, DEV_FADE_ADDR, DEV_OFFS_ADDR};
	initial begin
		forever #20 clock = ~clock;
	end
	rtr_host #(.POR_CYC(200), .RSTW_CYC(100), .HALF_CYC(4)) u_rtr_host (
		.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso),
		.reset_pin_o(rst_o), .reset_pin_oe(rst_oe), .reset_pin_i(rst_pin),
		.clock_output_pin(clk_out)
	);
	rtr_dev #(.READY_OSC(19)) u_rtr_dev (
		.por_n(rstn), .reset_pin(rst_pin), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
		.spi_miso(miso), .clock_output_pin(clk_out)
	);
	task automatic test_done();
		if (n_mismatch == 0 && checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// poll status until idle and ready; gives up and counts a mismatch after 2000 polls
	task automatic idle();
		for (int n = 0; n < 2000; n++) begin
			apb(1'b0, REG_STAT, 32'h0);
			if (rd[STAT_BUSY_BIT] === 1'b0 && rd[STAT_READY_BIT] === 1'b1) return;
		end
		n_mismatch++;
	endtask
	task automatic cmd(input int c, input int a, input int d, input int m);
		apb(1'b1, REG_XFER, {16'h0, d[7:0], 1'b0, a[6:0]});
		apb(1'b1, REG_CTRL, {22'h0, m[1:0], 5'h0, c[2:0]});
		idle();
	endtask
	task automatic dev_rd(input int a);
		cmd(2, a, 0, 0);
		chk(32'(rd[15:8]), ref_r[a]);
	endtask
	task automatic dflt();
		ref_r[DEV_SENS_ADDR] = SENS_NORMAL;
		ref_r[DEV_PA1_ADDR] = PA1_NORMAL;
		ref_r[DEV_PA2_ADDR] = PA2_NORMAL;
		ref_r[DEV_FADE_ADDR] = FADE_RESET;
		ref_r[DEV_OFFS_ADDR] = OFFS_RESET;
		foreach (adr[k]) dev_rd(adr[k]);
	endtask
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		test_done();
	end
	initial begin
		int v;
		time t0;
		v = $urandom(32'hDFA773DA);
		// reset falls by a scheduled update so every model sees a clean edge at time zero
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		apb(1'b0, REG_STAT, 32'h0);
		chk(32'(rd[2:0]), 32'h1);
		idle();
		chk(32'(rd[STAT_ACT_BIT]), 32'h1);
		dflt();
		for (int k = 3; k <= 4; k++) begin
			cmd(k, 0, 0, 0);
			ref_r[DEV_PA1_ADDR] = (k == 3) ? PA1_HIGH : PA1_NORMAL;
			ref_r[DEV_PA2_ADDR] = (k == 3) ? PA2_HIGH : PA2_NORMAL;
			dev_rd(DEV_PA1_ADDR);
			dev_rd(DEV_PA2_ADDR);
		end
		for (int k = 1; k >= 0; k--) begin
			cmd(5, 0, 0, k);
			ref_r[DEV_FADE_ADDR] = k ? FADE_NARROW_ON : FADE_NARROW_OFF;
			dev_rd(DEV_FADE_ADDR);
			cmd(7, 0, 0, 2 * k);
			ref_r[DEV_SENS_ADDR] = k ? SENS_HIGH : SENS_NORMAL;
			dev_rd(DEV_SENS_ADDR);
		end
		cmd(1, DEV_FADE_ADDR, FADE_OFF, 0);
		ref_r[DEV_FADE_ADDR] = FADE_OFF;
		dev_rd(DEV_FADE_ADDR);
		// raw write, then a second command while busy is refused
		v = $urandom;
		apb(1'b1, REG_XFER, {16'h0, v[7:0], 1'b0, DEV_OFFS_ADDR});
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b1, REG_CTRL, 32'h3);
		idle();
		chk(32'(rd[STAT_REFUSE_BIT]), 32'h1);
		ref_r[DEV_OFFS_ADDR] = v[7:0];
		dev_rd(DEV_OFFS_ADDR);
		dev_rd(DEV_PA1_ADDR);
		apb(1'b0, 8'h0C, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, REG_CTRL, 32'h300);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(32'(rd[9:8]), 32'h3);
		// manual reset brings every tuning register back
		cmd(3, 0, 0, 0);
		t0 = $time;
		cmd(6, 0, 0, 0);
		chk(32'(rd[1:0]), 32'h2);
		chk(32'($time - t0 >= (RST_PULSE_CYC + 100) * 40), 32'h1);
		dflt();
		test_done();
	end
endmodule
